/* File: common/usp_pkg.sv */
// Purpose: shared constants and types of serial port zero
// Assumes: the special function register space is byte addressed
// Notes: mode enum order follows the two-bit mode field
package usp_pkg;

    // register addresses on the special function register port
    localparam logic [7:0] USP_CTRL_ADDR = 8'h98;
    localparam logic [7:0] USP_DATA_ADDR = 8'h99;
    localparam logic [7:0] USP_RELL_ADDR = 8'h96;
    localparam logic [7:0] USP_RELH_ADDR = 8'h97;
    localparam logic [7:0] USP_RSRC_ADDR = 8'hD8;

    // control register field positions
    localparam int USP_MODE_HI = 7;
    localparam int USP_MODE_LO = 6;
    localparam int USP_MULTIPROC_EN_BIT = 5;
    localparam int USP_REN = 4;
    localparam int USP_TB8 = 3;
    localparam int USP_RB8 = 2;
    localparam int USP_TI = 1;
    localparam int USP_RI = 0;
    // rate source select position
    localparam int USP_RSRC_BIT = 7;

    // values after reset
    localparam logic [7:0] USP_CTRL_RST = 8'h00;
    localparam logic [7:0] USP_DATA_RST = 8'h00;
    localparam logic [9:0] USP_RELOAD_RST = 10'h000;
    localparam logic USP_RSRC_RST = 1'b0;

    // reload generator overflows when it reaches this count
    localparam logic [9:0] USP_GEN_TOP = 10'h3FF;

    // shift mode: one bit per twelve oscillator cycles
    localparam logic [3:0] USP_SHIFT_LAST = 4'hB;
    localparam logic [3:0] USP_SHIFT_HALF = 4'h6;

    // asynchronous modes: sixteen ticks per bit, sample at the centre
    localparam logic [3:0] USP_OVS_LAST = 4'hF;
    localparam logic [3:0] USP_OVS_CENTRE = 4'h7;

    // frame lengths and sample counts
    localparam logic [3:0] USP_BITS_SHIFT = 4'h8;
    localparam logic [3:0] USP_BITS_UART8 = 4'hA;
    localparam logic [3:0] USP_BITS_UART9 = 4'hB;
    localparam logic [3:0] USP_RX_LAST8 = 4'h8;
    localparam logic [3:0] USP_RX_LAST9 = 4'h9;

    // operating modes
    typedef enum logic [1:0] {
        USP_SHIFT,
        USP_UART8,
        USP_UART9F,
        USP_UART9V
    } usp_mode_t;

    // asynchronous receiver states
    typedef enum logic [1:0] {
        USP_RX_IDLE,
        USP_RX_START,
        USP_RX_BITS
    } usp_rx_state_t;

endpackage

/* File: core/usp_pair_buf.sv */
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: source and sink on the same clock
// Notes: in_ready drops only when both entries hold words
`timescale 1ns/1ps
`default_nettype none
module usp_pair_buf #(
    parameter int W = 9
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic [W-1:0] d0_ff;
    logic [W-1:0] d1_ff;
    logic [1:0] cnt_ff;
    logic push;
    logic pop;

    // honest full and empty from the count
    assign in_ready = cnt_ff != 2'h2;
    assign out_valid = cnt_ff != 2'h0;
    assign out_data = d0_ff;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // head entry, refilled from the tail or the input on a pop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            d0_ff <= '0;
            d1_ff <= '0;
            cnt_ff <= 2'h0;
        end else begin
            if (pop) begin
                d0_ff <= (cnt_ff == 2'h2) ? d1_ff : in_data;
            end else if (push && cnt_ff == 2'h0) begin
                d0_ff <= in_data;
            end
            if (push && cnt_ff == 2'h1 && !pop) begin
                d1_ff <= in_data;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule // usp_pair_buf
`default_nettype wire

/* File: core/usp_serial_port.sv */
// Purpose: serial port zero, shift-register and asynchronous modes
// Assumes: clk is the oscillator; register port and timer overflow on clk
// Notes: received words queue in a two-entry buffer ahead of the data register
// Notes on behaviour
// - rate from reload generator or timer overflow
// - one data register: write sends, read receives
// - new word accepted while previous unread
// - control bits 7:6 select among four modes
// - shift mode runs at oscillator over twelve
// - fixed 9-bit mode: clock over 32 or 64
// - control bit 5 enables multiprocessor filtering
// - control bit 4 enables reception
// - bit 2 gets ninth or stop bit
// - bit 1 set when transmit finishes
// - bit 0 set on reception, software clears
// - shift mode: data pin both ways, clock out
// - shift receive starts on write ren=1, ri=0
// - async modes receive when ren is set and the buffer has room
// - 8-bit frame: start, eight data, stop
// - start bit syncs; stop lands in bit 2
// - fixed 9-bit frame has eleven bits
// - ninth bit sent from bit 3, captured in 2
// - variable 9-bit mode uses selectable rate
// - transmit and receive run at once in async modes
// - rate source bit 7 picks timer or generator
// - generator reloads from low and high bytes
`timescale 1ns/1ps
`default_nettype none
module usp_serial_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // rate inputs
    input wire logic timer1_ovf,
    input wire logic rate_double_bit,
    // line pins
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    output logic serial_out_pin
);

    // nine-bit frame modes
    function automatic logic is_nine(input usp_pkg::usp_mode_t m);
        return m == usp_pkg::USP_UART9F || m == usp_pkg::USP_UART9V;
    endfunction
    // mode field of a control byte
    function automatic usp_pkg::usp_mode_t mode_of(input logic [7:0] b);
        return usp_pkg::usp_mode_t'(b[usp_pkg::USP_MODE_HI:usp_pkg::USP_MODE_LO]);
    endfunction

    logic [7:0] ctrl_ff, data_ff, rdata_ff;
    logic [9:0] rel_ff, gen_cnt_ff;
    logic [1:0] pre_ff;
    logic rsrc_ff, sync1_ff, sync2_ff, prev_ff;
    logic tx_busy_ff, m0_rx_ff, out_ff, dout_ff, doe_ff;
    logic [10:0] tx_shift_ff, shift_n;
    logic [3:0] tx_cnt_ff, tx_sub_ff, rx_tick_ff, rx_cnt_ff;
    usp_pkg::usp_rx_state_t rx_state_ff, nxt_rx_state;
    logic [8:0] rx_shift_ff, nxt_rx_shift, buf_out_data;
    // next values and pulses from the two sequencers
    logic busy_n, m0_rx_n, ti_set, m0_push, a_push;
    logic [3:0] cnt_n, sub_n, nxt_rx_tick, nxt_rx_cnt;
    // buffer handshake seen from the port
    logic buf_in_ready, buf_out_valid;

    // register port decode
    wire ctrl_wr = sfr_wr && sfr_addr == usp_pkg::USP_CTRL_ADDR;
    wire data_wr = sfr_wr && sfr_addr == usp_pkg::USP_DATA_ADDR;
    wire rell_wr = sfr_wr && sfr_addr == usp_pkg::USP_RELL_ADDR;
    wire relh_wr = sfr_wr && sfr_addr == usp_pkg::USP_RELH_ADDR;
    wire rsrc_wr = sfr_wr && sfr_addr == usp_pkg::USP_RSRC_ADDR;

    wire usp_pkg::usp_mode_t mode = mode_of(ctrl_ff);
    wire m0 = mode == usp_pkg::USP_SHIFT;
    wire nine = is_nine(mode);
    wire ren = ctrl_ff[usp_pkg::USP_REN];
    wire multiproc_en_bit = ctrl_ff[usp_pkg::USP_MULTIPROC_EN_BIT];
    wire rx_line = sync2_ff;

    // generator counts up from reload to top
    wire gen_ovf = gen_cnt_ff == usp_pkg::USP_GEN_TOP;
    // overflow source; picks timer or generator
    // fixed 9-bit mode overflows every clock
    // variable 9-bit mode follows the selected source
    wire ovf_src = (mode == usp_pkg::USP_UART9F) ? 1'b1 : (rsrc_ff ? gen_ovf : timer1_ovf);
    // sixteen ticks per bit: halve with doubling set, quarter without
    wire tick16 = ovf_src && (rate_double_bit ? pre_ff[0] : pre_ff == 2'h3);

    // buffer between receivers and the data register
    wire [8:0] m0_word = {1'b0, rx_line, tx_shift_ff[7:1]};
    wire [8:0] rx_new = {rx_line, rx_shift_ff[8:1]};
    wire [8:0] a_word = nine ? rx_shift_ff : rx_new;
    wire [8:0] buf_in_data = m0_push ? m0_word : a_word;
    wire buf_out_ready = !ctrl_ff[usp_pkg::USP_RI];
    wire pop = buf_out_valid && buf_out_ready;

    // received words wait here while the data register is unread
    usp_pair_buf #(
        .W(9)
    ) u_rx_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(a_push || m0_push),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // transmit and shift engine controls
    wire tx_start = data_wr && !tx_busy_ff;
    // shift receive triggered by the control write itself
    wire m0_rx_go = ctrl_wr && mode_of(sfr_wdata) == usp_pkg::USP_SHIFT
        && sfr_wdata[usp_pkg::USP_REN] && !sfr_wdata[usp_pkg::USP_RI] && !tx_busy_ff;
    wire m0_step = tx_busy_ff && m0 && tx_sub_ff == usp_pkg::USP_SHIFT_LAST;
    wire a_step = tx_busy_ff && !m0 && tick16 && tx_sub_ff == usp_pkg::USP_OVS_LAST;
    wire tx_last = tx_cnt_ff == 4'h1;
    // a full buffer stalls the last shift-in rather than losing the word
    wire m0_hold = m0_rx_ff && m0_step && tx_last && !buf_in_ready;
    // shift clock low for six of twelve cycles
    wire sclk = !(tx_busy_ff && m0 && tx_sub_ff < usp_pkg::USP_SHIFT_HALF);

    // transmit and shift-mode sequencing
    always_comb begin
        busy_n = tx_busy_ff;
        m0_rx_n = m0_rx_ff;
        shift_n = tx_shift_ff;
        cnt_n = tx_cnt_ff;
        sub_n = tx_sub_ff;
        ti_set = 1'b0;
        m0_push = 1'b0;
        if (tx_start) begin
            // data write loads the sender; frame build
            // ninth slot carries the software ninth bit
            busy_n = 1'b1;
            m0_rx_n = 1'b0;
            sub_n = 4'h0;
            cnt_n = m0 ? usp_pkg::USP_BITS_SHIFT
                : (nine ? usp_pkg::USP_BITS_UART9 : usp_pkg::USP_BITS_UART8);
            shift_n = m0 ? {3'h7, sfr_wdata}
                : {1'b1, nine ? ctrl_ff[usp_pkg::USP_TB8] : 1'b1, sfr_wdata, 1'b0};
        end else if (m0_rx_go) begin
            busy_n = 1'b1;
            m0_rx_n = 1'b1;
            sub_n = 4'h0;
            cnt_n = usp_pkg::USP_BITS_SHIFT;
            shift_n = '1;
        end else if (tx_busy_ff && !m0_hold) begin
            if (m0) begin
                sub_n = m0_step ? 4'h0 : tx_sub_ff + 4'h1;
            end else if (tick16) begin
                sub_n = tx_sub_ff + 4'h1;
            end
            if (m0_step || a_step) begin
                // lsb first; shift receive fills from the data pin
                shift_n = m0_rx_ff ? {3'h7, m0_word[7:0]} : {1'b1, tx_shift_ff[10:1]};
                cnt_n = tx_cnt_ff - 4'h1;
                if (tx_last) begin
                    busy_n = 1'b0;
                    m0_rx_n = 1'b0;
                    m0_push = m0_rx_ff;
                    // flag raised after the last bit ends: the stop bit, or the eighth bit of a shift-mode send
                    ti_set = !m0_rx_ff;
                end
            end
        end
    end

    // asynchronous receiver
    always_comb begin
        nxt_rx_state = rx_state_ff;
        nxt_rx_tick = rx_tick_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_shift = rx_shift_ff;
        a_push = 1'b0;
        // clearing enable drops any frame in progress
        if (!ren || m0) begin
            nxt_rx_state = usp_pkg::USP_RX_IDLE;
        end else begin
            unique case (rx_state_ff)
                usp_pkg::USP_RX_IDLE: begin
                    // armed by enable and a free buffer entry; falling edge
                    if (prev_ff && !rx_line && buf_in_ready) begin
                        nxt_rx_state = usp_pkg::USP_RX_START;
                        nxt_rx_tick = 4'h0;
                    end
                end
                usp_pkg::USP_RX_START: begin
                    if (tick16) begin
                        nxt_rx_tick = rx_tick_ff + 4'h1;
                        // start bit confirmed at its centre
                        if (rx_tick_ff == usp_pkg::USP_OVS_CENTRE) begin
                            nxt_rx_state = rx_line ? usp_pkg::USP_RX_IDLE : usp_pkg::USP_RX_BITS;
                            nxt_rx_cnt = 4'h0;
                        end
                    end
                end
                usp_pkg::USP_RX_BITS: begin
                    if (tick16) begin
                        nxt_rx_tick = rx_tick_ff + 4'h1;
                        if (rx_tick_ff == usp_pkg::USP_OVS_CENTRE) begin
                            nxt_rx_cnt = rx_cnt_ff + 4'h1;
                            if (rx_cnt_ff != usp_pkg::USP_RX_LAST9) begin
                                nxt_rx_shift = rx_new;
                            end
                            if (rx_cnt_ff == (nine ? usp_pkg::USP_RX_LAST9
                                    : usp_pkg::USP_RX_LAST8)) begin
                                nxt_rx_state = usp_pkg::USP_RX_IDLE;
                                a_push = !multiproc_en_bit || (nine ? rx_shift_ff[8] : rx_line);
                            end
                        end
                    end
                end
            endcase
        end
    end

    // pop sets the receive flag; hardware set beats a clear
    wire nxt_ri = pop || (ctrl_wr ? sfr_wdata[usp_pkg::USP_RI] : ctrl_ff[usp_pkg::USP_RI]);
    // transmit flag, set wins over a same-cycle clear
    wire nxt_ti = ti_set || (ctrl_wr ? sfr_wdata[usp_pkg::USP_TI] : ctrl_ff[usp_pkg::USP_TI]);
    // ninth or stop bit, untouched in shift mode
    wire nxt_rb8 = (pop && !m0) ? buf_out_data[8]
        : (ctrl_wr ? sfr_wdata[usp_pkg::USP_RB8] : ctrl_ff[usp_pkg::USP_RB8]);
    wire [7:0] nxt_ctrl = {ctrl_wr ? sfr_wdata[7:3] : ctrl_ff[7:3], nxt_rb8, nxt_ti, nxt_ri};

    // read multiplexer; unmapped addresses read zero
    wire [7:0] rd_val =
        (sfr_addr == usp_pkg::USP_CTRL_ADDR) ? ctrl_ff :
        (sfr_addr == usp_pkg::USP_DATA_ADDR) ? data_ff :
        (sfr_addr == usp_pkg::USP_RELL_ADDR) ? rel_ff[7:0] :
        (sfr_addr == usp_pkg::USP_RELH_ADDR) ? {6'h00, rel_ff[9:8]} :
        (sfr_addr == usp_pkg::USP_RSRC_ADDR) ? {rsrc_ff, 7'h00} : 8'h00;

    // software registers and read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= usp_pkg::USP_CTRL_RST;
            data_ff <= usp_pkg::USP_DATA_RST;
            rel_ff <= usp_pkg::USP_RELOAD_RST;
            rsrc_ff <= usp_pkg::USP_RSRC_RST;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            data_ff <= pop ? buf_out_data[7:0] : data_ff;
            rel_ff[7:0] <= rell_wr ? sfr_wdata : rel_ff[7:0];
            rel_ff[9:8] <= relh_wr ? sfr_wdata[1:0] : rel_ff[9:8];
            rsrc_ff <= rsrc_wr ? sfr_wdata[usp_pkg::USP_RSRC_BIT] : rsrc_ff;
            rdata_ff <= sfr_rd ? rd_val : rdata_ff;
        end
    end

    // rate generation; the generator runs always so switching is glitch free
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gen_cnt_ff <= usp_pkg::USP_RELOAD_RST;
            pre_ff <= 2'h0;
        end else begin
            gen_cnt_ff <= gen_ovf ? rel_ff : gen_cnt_ff + 10'h001;
            pre_ff <= ovf_src ? pre_ff + 2'h1 : pre_ff;
        end
    end

    // data pin synchroniser, then one more stage for the edge detector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            sync1_ff <= serial_data_pin_in;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // sender and receiver state run side by side
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_busy_ff <= 1'b0;
            m0_rx_ff <= 1'b0;
            tx_shift_ff <= '1;
            tx_cnt_ff <= 4'h0;
            tx_sub_ff <= 4'h0;
            rx_state_ff <= usp_pkg::USP_RX_IDLE;
            rx_tick_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
            rx_shift_ff <= '0;
        end else begin
            tx_busy_ff <= busy_n;
            m0_rx_ff <= m0_rx_n;
            tx_shift_ff <= shift_n;
            tx_cnt_ff <= cnt_n;
            tx_sub_ff <= sub_n;
            rx_state_ff <= nxt_rx_state;
            rx_tick_ff <= nxt_rx_tick;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_shift_ff <= nxt_rx_shift;
        end
    end

    // pins: shift clock or serial out, data pin driven on shift send
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_ff <= 1'b1;
            dout_ff <= 1'b1;
            doe_ff <= 1'b0;
        end else begin
            out_ff <= m0 ? sclk : tx_shift_ff[0];
            dout_ff <= tx_shift_ff[0];
            doe_ff <= tx_busy_ff && m0 && !m0_rx_ff;
        end
    end

    assign serial_out_pin = out_ff;
    assign serial_data_pin_out = dout_ff;
    assign serial_data_pin_oe = doe_ff;
    assign sfr_rdata = rdata_ff;

    // checks on the port's own outputs and state
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_clk_low6;
        !serial_out_pin [*6];
    endsequence
    a_shift_clk_low: assert property (
        (m0 && tx_busy_ff && $fell(serial_out_pin)) |-> s_clk_low6 ##1 serial_out_pin)
        else $error("shift clock low phase not six cycles");
    a_tx_start_low: assert property (
        (tx_start && !m0) |=> tx_busy_ff ##1 !serial_out_pin)
        else $error("start bit missing after data write");
    a_ninth_slot: assert property (
        (tx_start && nine) |=> tx_shift_ff[9] == $past(ctrl_ff[usp_pkg::USP_TB8]))
        else $error("ninth bit not taken from control");
    a_ti_set_wins: assert property (
        (ti_set && ctrl_wr) |=> ctrl_ff[usp_pkg::USP_TI])
        else $error("transmit flag lost to a clear");
    a_ri_pop_data: assert property (
        pop |=> ctrl_ff[usp_pkg::USP_RI] && data_ff == $past(buf_out_data[7:0]))
        else $error("receive flag or data not updated");
    a_rx_off_idle: assert property (
        !ren |=> rx_state_ff == usp_pkg::USP_RX_IDLE)
        else $error("receiver active while disabled");
    a_shift_rx_go: assert property (
        m0_rx_go |=> tx_busy_ff && m0_rx_ff ##1 !serial_data_pin_oe)
        else $error("shift receive did not start");
    a_gen_reload: assert property (
        gen_ovf |=> gen_cnt_ff == $past(rel_ff))
        else $error("generator did not reload");
    a_shift_oe: assert property (
        (tx_start && m0) |=> ##1 serial_data_pin_oe)
        else $error("data pin not driven in shift send");

endmodule // usp_serial_port
`default_nettype wire

/* File: tb/usp_peer.sv */
// Purpose: remote serial peer and shift register device for serial port zero
// Assumes: all line changes follow rising clk edges
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module usp_peer (
    // clock
    input wire logic clk,
    // line side
    input wire logic line_in,
    input wire logic pin_in,
    output logic line_out
);
    // idle line sits high
    initial line_out = 1'b1;

    // bounded wait for a level on the port's out pin
    task automatic wait_lvl(input logic v, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 8000 && !ok; i++) begin
            @(posedge clk);
            ok = (line_in === v);
        end
    endtask

    // low start, data lsb first, ninth, high stop
    task automatic send_async(input logic [8:0] d, input int nd, input int per);
        for (int i = -1; i <= nd; i++) begin
            line_out <= (i < 0) ? 1'b0 : (i == nd) ? 1'b1 : d[i];
            repeat (per) @(posedge clk);
        end
    endtask

    // samples each bit at its centre; d[nd] holds the stop bit
    task automatic recv_async(output logic [9:0] d, input int nd, input int per, output bit ok);
        d = '0;
        wait_lvl(1'b0, ok);
        repeat (per / 2) @(posedge clk);
        ok = ok && (line_in === 1'b0);
        for (int i = 0; i <= nd; i++) begin
            repeat (per) @(posedge clk);
            d[i] = line_in;
        end
    endtask

    // device answers each clock fall, lsb first
    task automatic shift_feed(input logic [7:0] d, output bit ok);
        bit k;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wait_lvl(1'b0, k);
            line_out <= d[i];
            ok = ok && k;
            wait_lvl(1'b1, k);
            ok = ok && k;
        end
        repeat (6) @(posedge clk);
        line_out <= ~d[7];
    endtask

    // captures data on clock rise; per is the average bit period in clocks
    task automatic shift_watch(output logic [7:0] d, output int per, output bit ok);
        bit k;
        longint t0;
        ok = 1'b1;
        t0 = 0;
        per = 0;
        for (int i = 0; i < 8; i++) begin
            wait_lvl(1'b0, k);
            if (i == 0) t0 = $time;
            if (i == 7) per = int'(($time - t0) / 28);
            ok = ok && k;
            wait_lvl(1'b1, k);
            d[i] = pin_in;
            ok = ok && k;
        end
    endtask
endmodule // usp_peer
`default_nettype wire

/* File: tb/usp_serial_port_tb.sv */
// Purpose: self-checking bench for serial port zero
// Assumes: register port strobes of one cycle, read data one cycle later
// Notes: timer overflow pulses every other clock, giving 64 clocks a bit
`timescale 1ns/1ps
`default_nettype none
module usp_serial_port_tb;
    logic clk, rst, sfr_wr, sfr_rd, timer1_ovf, rate_double_bit;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, b0, b1;
    logic pin_out, pin_oe, out_pin, peer_line, tb8, n9;
    wire pin_in;
    logic [9:0] f;
    int mismatches, check_count, seed, per, m;
    bit ok;
    // the data pin follows whichever party drives it
    assign pin_in = pin_oe ? pin_out : peer_line;
    usp_serial_port uut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .timer1_ovf(timer1_ovf), .rate_double_bit(rate_double_bit),
        .serial_data_pin_in(pin_in), .serial_data_pin_out(pin_out),
        .serial_data_pin_oe(pin_oe), .serial_out_pin(out_pin));
    usp_peer peer (.clk(clk), .line_in(out_pin), .pin_in(pin_in), .line_out(peer_line));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // overflow every second clock
    always @(posedge clk) timer1_ovf <= ~timer1_ovf;

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // a failed bounded wait ends the run
    task automatic need(input bit c);
        if (!c) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(posedge clk);
        #1 d = sfr_rdata;
    endtask
    task automatic wait_flag(input int b);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 1500 && c[b] !== 1'b1; i++) rd(usp_pkg::USP_CTRL_ADDR, c);
        need(c[b] === 1'b1);
    endtask
    // sends a frame from the peer, then checks nothing was taken
    task automatic no_rx(input logic [8:0] d);
        peer.send_async(d, 9, 32);
        repeat (40) @(posedge clk);
        rd(usp_pkg::USP_CTRL_ADDR, v);
        chk("ri stays clear", 1'b0, v[0]);
    endtask

    initial begin
        seed = 16;
        rst = 1'b1;
        {sfr_wr, sfr_rd, timer1_ovf, rate_double_bit} = 4'h1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped place, masked bits
        rd(8'h98, v);
        chk("ctrl reset", 8'h00, v);
        rd(8'h99, v);
        chk("data reset", 8'h00, v);
        wr(8'h50, 8'hFF);
        rd(8'h50, v);
        chk("unmapped", 8'h00, v);
        wr(usp_pkg::USP_RSRC_ADDR, 8'hFF);
        rd(usp_pkg::USP_RSRC_ADDR, v);
        chk("rate source", 8'h80, v);
        wr(usp_pkg::USP_RELH_ADDR, 8'hFF);
        rd(usp_pkg::USP_RELH_ADDR, v);
        chk("reload high", 8'h03, v);
        wr(usp_pkg::USP_RELL_ADDR, 8'hFF);
        $display("test registers done");
        // modes 1..3 send and receive together; random bytes and ninth bits
        for (m = 1; m < 4; m++) begin
            per = (m == 3) ? 32 : 64;
            rate_double_bit <= (m != 2);
            wr(usp_pkg::USP_RSRC_ADDR, (m == 3) ? 8'h80 : 8'h00);
            tb8 = 1'($random(seed));
            n9 = 1'($random(seed));
            b0 = 8'($random(seed));
            b1 = 8'($random(seed));
            wr(usp_pkg::USP_CTRL_ADDR, {m[1:0], 2'b01, tb8, 3'b000});
            fork
                peer.send_async({n9, b1}, (m == 1) ? 8 : 9, per);
                begin
                    wr(usp_pkg::USP_DATA_ADDR, b0);
                    peer.recv_async(f, (m == 1) ? 8 : 9, per, ok);
                end
            join
            need(ok);
            chk("tx frame", (m == 1) ? {2'b01, b0} : {1'b1, tb8, b0}, f);
            wait_flag(1);
            wait_flag(0);
            rd(usp_pkg::USP_DATA_ADDR, v);
            chk("rx byte", b1, v);
            rd(usp_pkg::USP_CTRL_ADDR, v);
            chk("ctrl", {m[1:0], 2'b01, tb8, (m == 1) ? 1'b1 : n9, 2'b11}, v);
            wr(usp_pkg::USP_CTRL_ADDR, {m[1:0], 6'h10});
            $display("test async mode %0d done", m);
        end
        // two words arrive before software reads the first
        peer.send_async({1'b1, b0}, 9, 32);
        peer.send_async({1'b1, b1}, 9, 32);
        wait_flag(0);
        rd(usp_pkg::USP_DATA_ADDR, v);
        chk("first word", b0, v);
        wr(usp_pkg::USP_CTRL_ADDR, 8'hD0);
        wait_flag(0);
        rd(usp_pkg::USP_DATA_ADDR, v);
        chk("second word", b1, v);
        $display("test double buffer done");
        // address marker filter, then receiver switched off
        wr(usp_pkg::USP_CTRL_ADDR, 8'hF0);
        no_rx({1'b0, b0});
        peer.send_async({1'b1, b0}, 9, 32);
        wait_flag(0);
        wr(usp_pkg::USP_CTRL_ADDR, 8'hC0);
        no_rx({1'b1, b1});
        $display("test filter and enable done");
        // shift mode send then receive
        wr(usp_pkg::USP_CTRL_ADDR, 8'h00);
        fork
            wr(usp_pkg::USP_DATA_ADDR, b1);
            peer.shift_watch(v, per, ok);
        join
        need(ok);
        chk("shift tx byte", b1, v);
        chk("shift period", 10'd12, 10'(per));
        wait_flag(1);
        fork
            wr(usp_pkg::USP_CTRL_ADDR, 8'h10);
            peer.shift_feed(b0, ok);
        join
        need(ok);
        wait_flag(0);
        rd(usp_pkg::USP_DATA_ADDR, v);
        chk("shift rx byte", b0, v);
        $display("test shift mode done");
        tally_and_finish();
    end
endmodule // usp_serial_port_tb
`default_nettype wire
